// File: hdl/spkdg_chan.sv
`timescale 1ns/10ps
module spkdg_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic diag_en_i,
  input wire logic perm_i,
  input wire logic armed_i,
  input wire logic tick_1ms_i,
  input wire logic acq_done_i,
  input wire logic overload_i,
  input wire logic fault_gnd_pos_i,
  input wire logic fault_gnd_neg_i,
  input wire logic fault_vs_i,
  input wire logic fault_short_i,
  output logic active_o,
  output logic cycle_o,
  output logic [3:0] fault_o
);
  import spkdg_pkg::*;
  parameter bit SRC_POS = 1'b1;
  spkdg_ch_t st_q;
  logic gnd_src, gnd_sink;
  logic [3:0] fault_d;
  assign gnd_src = SRC_POS ? fault_gnd_pos_i : fault_gnd_neg_i;
  assign gnd_sink = SRC_POS ? fault_gnd_neg_i : fault_gnd_pos_i;
  always_comb begin
    fault_d = 4'h0;
    if (fault_vs_i) begin
      fault_d[DB_VS] = 1'b1;
      fault_d[DB_GND] = gnd_src;
    end else if (gnd_src || gnd_sink) begin
      fault_d[DB_GND] = 1'b1;
    end else if (fault_short_i) begin
      fault_d[DB_SHORT] = 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= SPKDG_RUN;
      fault_o <= 4'h0;
    end else if (ce_i) begin
      case (st_q)
        SPKDG_RUN: begin
          if (overload_i && perm_i) begin
            st_q <= (diag_en_i && armed_i) ? SPKDG_WAIT1 : SPKDG_RESTART;
          end
        end
        SPKDG_WAIT1: begin
          if (tick_1ms_i) begin
            st_q <= overload_i ? SPKDG_DIAG : SPKDG_RUN;
          end
        end
        SPKDG_DIAG: begin
          if (!overload_i) begin
            fault_o <= 4'h0;
          end else if (acq_done_i) begin
            fault_o <= fault_d;
            st_q <= SPKDG_RESTART;
          end
        end
        SPKDG_RESTART: begin
          if (tick_1ms_i && !overload_i) begin
            st_q <= SPKDG_RUN;
          end
        end
        default: st_q <= SPKDG_RUN;
      endcase
    end
  end
  assign active_o = (st_q == SPKDG_RUN) || (st_q == SPKDG_WAIT1);
  assign cycle_o = (st_q == SPKDG_DIAG);
endmodule

// File: hdl/spkdg_pkg.sv
package spkdg_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RECHECK_US = 1000;
  localparam int unsigned ACQ_MS = 100;
  localparam int unsigned RECHECK_CYC = (CLK_HZ / 1000000) * RECHECK_US;
  localparam int unsigned ACQ_CYC = (CLK_HZ / 1000) * ACQ_MS;
  localparam int unsigned NCH = 4;
  localparam int unsigned AC_PEAKS_MIN = 3;
  localparam int unsigned IB1_OFS_EN = 5;
  localparam int unsigned IB1_DIAG_EN = 6;
  localparam int unsigned IB1_GAIN_F = 4;
  localparam int unsigned IB1_GAIN_R = 3;
  localparam int unsigned IB2_AC_EN = 2;
  localparam int unsigned IB2_LINE = 3;
  localparam int unsigned IB2_RUN = 4;
  localparam int unsigned DB_GND = 0;
  localparam int unsigned DB_VS = 1;
  localparam int unsigned DB_OPEN = 2;
  localparam int unsigned DB_SHORT = 3;
  localparam int unsigned DB_PERM = 4;
  localparam int unsigned DB_ACOPEN = 5;
  localparam int unsigned DB_DONE = 6;
  localparam int unsigned DB2_OFS_ACT = 7;
  // Channel order: 0 left front, 1 left rear, 2 right front, 3 right rear
  localparam logic [3:0] SRC_IS_POS = 4'h9;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    SPKDG_IDLE, SPKDG_PULSE, SPKDG_PERM
  } spkdg_top_t;
  typedef enum logic [1:0] {
    SPKDG_RUN, SPKDG_WAIT1, SPKDG_DIAG, SPKDG_RESTART
  } spkdg_ch_t;
endpackage

// File: hdl/spkdg_top.sv
`timescale 1ns/10ps
module spkdg_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] first_instruction_byte_i,
  input wire logic [7:0] second_instruction_byte_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [3:0] gnd_pos_i,
  input wire logic [3:0] gnd_neg_i,
  input wire logic [3:0] vs_i,
  input wire logic [3:0] short_i,
  input wire logic [3:0] open_i,
  input wire logic [3:0] overload_i,
  input wire logic [3:0] offset_i,
  input wire logic [3:0] peak_i,
  output logic standby_o,
  output logic pulse_o,
  output logic line_thr_o,
  output logic [3:0] ch_active_o,
  output logic [7:0] first_diagnostic_byte_o,
  output logic [7:0] lr_diag_byte_o,
  output logic [7:0] rf_diag_byte_o,
  output logic [7:0] rr_diag_byte_o
);
  import spkdg_pkg::*;
  logic [3:0] gp_s1, gp_q, gn_s1, gn_q, vs_s1, vs_q, sh_s1, sh_q;
  logic [3:0] op_s1, op_q, ov_s1, ov_q, of_s1, of_q, pk_s1, pk_q;
  logic [7:0] ib1_q, ib2_q;
  logic run_prev_q;
  spkdg_top_t top_q;
  logic [31:0] acq_cnt_q;
  logic [15:0] ms_cnt_q;
  logic tick_1ms, acq_done, armed_q, done_q;
  logic [3:0] perm_q;
  logic [3:0] ton_q [NCH];
  logic [3:0] ton_fault [NCH];
  logic [3:0] ch_fault [NCH];
  logic [3:0] ch_cycle, ch_act;
  logic [3:0] ofs_q, pk_prev_q;
  logic [1:0] pk_cnt_q [NCH];
  logic [7:0] db_q [NCH];
  logic [7:0] db_d [NCH];
  logic ofs_win_q, ac_win_q;
  logic start_ton;
  logic [7:0] nib1;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {gp_s1, gp_q, gn_s1, gn_q, vs_s1, vs_q, sh_s1, sh_q} <= '0;
      {op_s1, op_q, ov_s1, ov_q, of_s1, of_q, pk_s1, pk_q} <= '0;
    end else if (ce_i) begin
      gp_s1 <= gnd_pos_i;
      gp_q <= gp_s1;
      gn_s1 <= gnd_neg_i;
      gn_q <= gn_s1;
      vs_s1 <= vs_i;
      vs_q <= vs_s1;
      sh_s1 <= short_i;
      sh_q <= sh_s1;
      op_s1 <= open_i;
      op_q <= op_s1;
      ov_s1 <= overload_i;
      ov_q <= ov_s1;
      of_s1 <= offset_i;
      of_q <= of_s1;
      pk_s1 <= peak_i;
      pk_q <= pk_s1;
    end
  end
  // Control bytes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ib1_q <= BYTE_ZERO;
      ib2_q <= BYTE_ZERO;
      run_prev_q <= 1'b0;
    end else if (ce_i) begin
      if (write_i) begin
        ib1_q <= first_instruction_byte_i;
        ib2_q <= second_instruction_byte_i;
      end
      run_prev_q <= ib2_q[IB2_RUN];
    end
  end
  assign nib1 = first_instruction_byte_i;
  assign line_thr_o = ib2_q[IB2_LINE] && ib1_q[IB1_GAIN_F]
                      && ib1_q[IB1_GAIN_R];
  assign start_ton = ib2_q[IB2_RUN] && !run_prev_q;
  // Turn-on pulse and acquisition timer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      top_q <= SPKDG_IDLE;
      acq_cnt_q <= '0;
    end else if (ce_i) begin
      case (top_q)
        SPKDG_IDLE: begin
          if (start_ton && ib1_q[IB1_DIAG_EN] && armed_q) begin
            top_q <= SPKDG_PULSE;
          end else if (start_ton) begin
            top_q <= SPKDG_PERM;
          end
        end
        SPKDG_PULSE: begin
          if (acq_done) begin
            top_q <= SPKDG_PERM;
          end
        end
        SPKDG_PERM: begin
          if (!ib2_q[IB2_RUN]) begin
            top_q <= SPKDG_IDLE;
          end
        end
        default: top_q <= SPKDG_IDLE;
      endcase
      if (top_q == SPKDG_PULSE || (|ch_cycle)) begin
        acq_cnt_q <= acq_done ? '0 : acq_cnt_q + 32'h1;
      end else begin
        acq_cnt_q <= '0;
      end
    end
  end
  assign acq_done = (acq_cnt_q == ACQ_CYC - 1);
  assign pulse_o = (top_q == SPKDG_PULSE);
  assign standby_o = (top_q != SPKDG_PERM);
  // 1 ms recheck tick, shared by all channels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_q <= '0;
    end else if (ce_i) begin
      ms_cnt_q <= tick_1ms ? '0 : ms_cnt_q + 16'h1;
    end
  end
  assign tick_1ms = (ms_cnt_q == 16'(RECHECK_CYC - 1));
  // Cycle arming: re-armed by a read, spent when a cycle ends; a cycle end wins over a read in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b1;
      done_q <= 1'b0;
    end else if (ce_i) begin
      if ((top_q == SPKDG_PULSE || (|ch_cycle)) && acq_done) begin
        armed_q <= 1'b0;
        done_q <= 1'b1;
      end else if (read_i) begin
        armed_q <= 1'b1;
        done_q <= 1'b0;
      end
    end
  end
  // Per channel turn-on result, held until the next turn-on pulse ends
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    always_comb begin
      ton_fault[g] = 4'h0;
      if (vs_q[g]) begin
        ton_fault[g][DB_VS] = 1'b1;
        ton_fault[g][DB_GND] = SRC_IS_POS[g] ? gp_q[g] : gn_q[g];
      end else if ((SRC_IS_POS[g] ? gn_q[g] : gp_q[g]) && op_q[g]) begin
        ton_fault[g][DB_OPEN] = 1'b1;
      end else if (gp_q[g] || gn_q[g]) begin
        ton_fault[g][DB_GND] = 1'b1;
      end else if (sh_q[g]) begin
        ton_fault[g][DB_SHORT] = 1'b1;
      end else if (op_q[g]) begin
        ton_fault[g][DB_OPEN] = 1'b1;
      end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        ton_q[g] <= 4'h0;
        perm_q[g] <= 1'b0;
      end else if (ce_i) begin
        if (top_q == SPKDG_PULSE && acq_done) begin
          ton_q[g] <= ton_fault[g];
          perm_q[g] <= 1'b0;
        end else if (ch_cycle[g]) begin
          perm_q[g] <= 1'b1;
        end
      end
    end
    spkdg_chan #(.SRC_POS(SRC_IS_POS[g])) u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .diag_en_i(ib1_q[IB1_DIAG_EN]),
      .perm_i(top_q == SPKDG_PERM),
      .armed_i(armed_q),
      .tick_1ms_i(tick_1ms),
      .acq_done_i(acq_done),
      .overload_i(ov_q[g]),
      .fault_gnd_pos_i(gp_q[g]),
      .fault_gnd_neg_i(gn_q[g]),
      .fault_vs_i(vs_q[g]),
      .fault_short_i(sh_q[g]),
      .active_o(ch_act[g]),
      .cycle_o(ch_cycle[g]),
      .fault_o(ch_fault[g])
    );
    // Offset must hold across the window; AC needs three peaks
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        ofs_q[g] <= 1'b0;
        pk_prev_q[g] <= 1'b0;
        pk_cnt_q[g] <= 2'h0;
      end else if (ce_i) begin
        pk_prev_q[g] <= pk_q[g];
        if (read_i || (write_i && nib1[IB1_OFS_EN] && !ib1_q[IB1_OFS_EN]))
        begin
          ofs_q[g] <= 1'b1;
        end else if (!of_q[g] || (|ov_q)) begin
          ofs_q[g] <= 1'b0;
        end
        if (read_i || !ac_win_q) begin
          pk_cnt_q[g] <= 2'h0;
        end else if (pk_q[g] && !pk_prev_q[g]
                     && pk_cnt_q[g] != 2'(AC_PEAKS_MIN)) begin
          pk_cnt_q[g] <= pk_cnt_q[g] + 2'h1;
        end
      end
    end
    always_comb begin
      db_d[g] = BYTE_ZERO;
      db_d[g][3:0] = perm_q[g] ? ch_fault[g] : ton_q[g];
      if (ofs_win_q && ofs_q[g] && !perm_q[g] && ton_q[g] == 4'h0) begin
        db_d[g][DB_OPEN] = 1'b1;
      end
      db_d[g][DB_PERM] = perm_q[g];
      db_d[g][DB_ACOPEN] = ac_win_q
                           && pk_cnt_q[g] != 2'(AC_PEAKS_MIN);
    end
  end
  // Windows for the offset and AC tests, abandoned on protection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ofs_win_q <= 1'b0;
      ac_win_q <= 1'b0;
    end else if (ce_i) begin
      if (|ov_q) begin
        ofs_win_q <= 1'b0;
        ac_win_q <= 1'b0;
      end else begin
        ofs_win_q <= ib1_q[IB1_OFS_EN];
        ac_win_q <= ib2_q[IB2_AC_EN];
      end
    end
  end
  // Read snapshot: the read returns the previous cycle's results
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCH; i++) begin
        db_q[i] <= BYTE_ZERO;
      end
    end else if (ce_i && read_i) begin
      for (int i = 0; i < NCH; i++) begin
        db_q[i] <= db_d[i];
      end
      db_q[0][DB_DONE] <= done_q;
      db_q[1][DB2_OFS_ACT] <= ofs_win_q;
    end
  end
  assign first_diagnostic_byte_o = db_q[0];
  assign lr_diag_byte_o = db_q[1];
  assign rf_diag_byte_o = db_q[2];
  assign rr_diag_byte_o = db_q[3];
  assign ch_active_o = ch_act & {NCH{!standby_o}};

  property p_pulse_standby;
    @(posedge clk_i) disable iff (rst_i) pulse_o |-> standby_o;
  endproperty
  a_pulse_standby: assert property (p_pulse_standby)
    else $error("pulse outside standby");
  property p_read_arms;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && read_i && !(|ch_cycle) && !pulse_o) |=> armed_q;
  endproperty
  a_read_arms: assert property (p_read_arms)
    else $error("read did not re-arm");
  property p_off_in_standby;
    @(posedge clk_i) disable iff (rst_i) standby_o |-> (ch_active_o == 4'h0);
  endproperty
  a_off_in_standby: assert property (p_off_in_standby)
    else $error("channel active in standby");
  property p_pulse_to_perm;
    @(posedge clk_i) disable iff (rst_i) $fell(pulse_o) |-> !standby_o;
  endproperty
  a_pulse_to_perm: assert property (p_pulse_to_perm)
    else $error("pulse end did not bias the stage");
  property p_done_flag;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && read_i) |=> first_diagnostic_byte_o[DB_DONE] == $past(done_q);
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("done bit not captured at read");
  // Bytes move only at a read, so a host never sees a half update
  property p_bytes_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(ce_i && read_i) |=> ($stable(first_diagnostic_byte_o)
        && $stable(lr_diag_byte_o) && $stable(rf_diag_byte_o)
        && $stable(rr_diag_byte_o));
  endproperty
  a_bytes_hold: assert property (p_bytes_hold)
    else $error("result bytes moved without a read");
  property p_cycle_done;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && (|ch_cycle) && acq_done) |=> (done_q && !armed_q);
  endproperty
  a_cycle_done: assert property (p_cycle_done)
    else $error("diagnostic cycle end not recorded");
  c_pulse: cover property (@(posedge clk_i) disable iff (rst_i) pulse_o);
  c_diag: cover property (@(posedge clk_i) disable iff (rst_i) |ch_cycle);
  c_done: cover property (@(posedge clk_i) disable iff (rst_i) done_q);
endmodule

// File: testbench/spkdg_host.sv
`timescale 1ns/10ps
module spkdg_host (
  input wire logic clk_i,
  output logic write_o,
  output logic read_o,
  output logic [7:0] ib1_o,
  output logic [7:0] ib2_o
);
  initial begin
    write_o = 1'b0;
    read_o = 1'b0;
    ib1_o = 8'h00;
    ib2_o = 8'h00;
  end
  // Both bytes go in one step so run and diag enable can coincide
  task automatic send_cfg(input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk_i);
    ib1_o <= b1;
    ib2_o <= b2;
    write_o <= 1'b1;
    @(posedge clk_i);
    write_o <= 1'b0;
    // Released bytes change so a stale value is never mistaken for a write
    ib1_o <= ~b1;
    ib2_o <= ~b2;
  endtask
  // Waits past the edge that updates the result bytes
  task automatic read_diag();
    @(posedge clk_i);
    read_o <= 1'b1;
    @(posedge clk_i);
    read_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// File: testbench/spkdg_top_bench.sv
`timescale 1ns/10ps
module spkdg_top_bench;
  import spkdg_pkg::*;
  localparam logic [7:0] G1 [4] = '{8'h18, 8'h18, 8'h10, 8'h08};
  localparam logic [7:0] G2 [4] = '{8'h08, 8'h00, 8'h08, 8'h08};
  logic clk_i;
  logic rst_i;
  logic ce_i;
  logic write_i;
  logic read_i;
  logic standby_o;
  logic pulse_o;
  logic line_thr_o;
  logic [3:0] overload_i;
  logic [3:0] offset_i;
  logic [3:0] peak_i;
  logic [3:0] ch_active_o;
  logic [7:0] ib1_i;
  logic [7:0] ib2_i;
  logic [7:0] db1_o;
  logic [7:0] lr_o;
  logic [7:0] rf_o;
  logic [7:0] rr_o;
  int n_errors;
  int samples_checked;
  int cycles;

  spkdg_host i_spkdg_host (
    .clk_i(clk_i), .write_o(write_i), .read_o(read_i),
    .ib1_o(ib1_i), .ib2_o(ib2_i)
  );

  // Fault comparators stay quiet: turn-on results need a full pulse
  spkdg_top i_spkdg_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .first_instruction_byte_i(ib1_i), .second_instruction_byte_i(ib2_i),
    .write_i(write_i), .read_i(read_i),
    .gnd_pos_i(4'h0), .gnd_neg_i(4'h0), .vs_i(4'h0), .short_i(4'h0),
    .open_i(4'h0), .overload_i(overload_i), .offset_i(offset_i),
    .peak_i(peak_i), .standby_o(standby_o), .pulse_o(pulse_o),
    .line_thr_o(line_thr_o), .ch_active_o(ch_active_o),
    .first_diagnostic_byte_o(db1_o), .lr_diag_byte_o(lr_o),
    .rf_diag_byte_o(rf_o), .rr_diag_byte_o(rr_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_ch(input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (ch_active_o[idx] !== val && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    overload_i <= 4'h0;
    offset_i <= 4'h0;
    peak_i <= 4'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    overload_i = 4'h0;
    offset_i = 4'h0;
    peak_i = 4'h0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    do_reset();
    chk({1'b0, standby_o, pulse_o, line_thr_o, ch_active_o}, 8'h40);
    chk(db1_o | lr_o | rf_o | rr_o, 8'h00);
    i_spkdg_host.send_cfg(8'h40, 8'h10);
    repeat (4) @(posedge clk_i);
    chk({1'b0, standby_o, pulse_o, line_thr_o, ch_active_o}, 8'h60);
    repeat (1000) @(posedge clk_i);
    i_spkdg_host.read_diag();
    chk({5'h00, standby_o, pulse_o, db1_o[DB_DONE]}, 8'h06);
    do_reset();
    for (int i = 0; i < 4; i++) begin
      i_spkdg_host.send_cfg(G1[i], G2[i]);
      repeat (4) @(posedge clk_i);
      chk({7'h00, line_thr_o}, {7'h00, i == 0});
    end
    // Restart mode: only the overloaded channel drops out
    do_reset();
    i_spkdg_host.send_cfg(8'h00, 8'h10);
    wait_ch(0, 1'b1, 50);
    chk({4'h0, ch_active_o}, 8'h0f);
    overload_i <= 4'h2;
    wait_ch(1, 1'b0, 20);
    chk({4'h0, ch_active_o}, 8'h0d);
    repeat (RECHECK_CYC + 100) @(posedge clk_i);
    chk({4'h0, ch_active_o}, 8'h0d);
    overload_i <= 4'h0;
    wait_ch(1, 1'b1, RECHECK_CYC + 20);
    chk({4'h0, ch_active_o}, 8'h0f);
    // Diag enable while running gives no pulse; short glitch is no fault
    i_spkdg_host.send_cfg(8'h40, 8'h10);
    repeat (4) @(posedge clk_i);
    chk({7'h00, pulse_o}, 8'h00);
    overload_i <= 4'h4;
    wait_ch(2, 1'b0, 20);
    repeat (100) @(posedge clk_i);
    overload_i <= 4'h0;
    wait_ch(2, 1'b1, RECHECK_CYC + 20);
    chk({4'h0, ch_active_o}, 8'h0f);
    i_spkdg_host.read_diag();
    i_spkdg_host.read_diag();
    chk({7'h00, db1_o[DB_DONE]}, 8'h00);
    chk({4'h0, rf_o[3:0]}, 8'h00);
    // Offset on channel 0 over the whole window; 3 peaks vs 2 peaks
    do_reset();
    offset_i <= 4'h1;
    repeat (5) @(posedge clk_i);
    i_spkdg_host.send_cfg(8'h20, 8'h14);
    wait_ch(0, 1'b1, 50);
    for (int k = 0; k < 3; k++) begin
      peak_i <= (k < 2) ? 4'h3 : 4'h1;
      repeat (4) @(posedge clk_i);
      peak_i <= 4'h0;
      repeat (4) @(posedge clk_i);
    end
    repeat (20) @(posedge clk_i);
    i_spkdg_host.read_diag();
    chk({5'h00, db1_o[DB_ACOPEN], db1_o[DB_OPEN], lr_o[DB_ACOPEN]},
        8'h03);
    chk({7'h00, lr_o[DB2_OFS_ACT]}, 8'h01);
    // Offset drops too late to reach this read's window; the next sees it
    offset_i <= 4'h0;
    i_spkdg_host.read_diag();
    chk({7'h00, db1_o[DB_OPEN]}, 8'h01);
    chk({7'h00, db1_o[DB_ACOPEN]}, 8'h01);
    i_spkdg_host.read_diag();
    chk({7'h00, db1_o[DB_OPEN]}, 8'h00);
    close_out();
  end
endmodule
